/* File: hw/adc_cfg_pkg.sv */
package adc_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] channel_config_offset = 8'h04;
  localparam logic [7:0] sequence_config_offset = 8'h0C;
  localparam logic [7:0] accumulate_count_offset = 8'h10;
  localparam logic [7:0] irq_status_offset = 8'h40;
  localparam logic [7:0] irq_mask_offset = 8'h44;
  localparam logic [7:0] accumulated_result_offset = 8'h48;
  localparam logic [7:0] result_offset = 8'h4C;
  // writable bit masks, reserved bits read zero
  localparam logic [31:0] channel_config_mask = 32'h0000_2F6F;
  localparam logic [31:0] sequence_config_mask = 32'h0003_FFFF;
  localparam logic [31:0] accumulate_count_mask = 32'h0000_01FF;
  localparam logic [31:0] config_reset = 32'h0000_0000;
  // field positions
  localparam int all_window_bit = 13;
  localparam int window_channel_lsb = 8;
  localparam int justify_bit = 6;
  localparam int discard_bit = 5;
  localparam int single_channel_lsb = 0;
  localparam int accumulator_clear_bit = 9;
  localparam int accumulate_enable_bit = 8;
  localparam int count_lsb = 0;
  localparam int sequence_length_lsb = 16;
  // interrupt bits
  localparam int irq_width = 4;
  localparam int irq_conversion_done = 0;
  localparam int irq_in_window = 1;
  localparam int irq_overrun = 2;
  localparam int irq_run_done = 3;
  // operating mode codes; only the two multiple modes honour the conversion count
  localparam logic [2:0] mode_single_multiple = 3'h1;
  localparam logic [2:0] mode_sequence_multiple = 3'h5;
  localparam logic [2:0] mode_single_once = 3'h0;

  typedef struct packed {
    logic all_channel_window_enable;
    logic [3:0] window_monitor_channel_select;
    logic justify_left;
    logic discard_new;
    logic [3:0] single_channel_select;
    logic accumulate_enable;
    logic [7:0] conversion_count;
    logic [1:0] sequence_length;
    logic [15:0] sequence_slots;
  } config_type;

  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [11:0] value;
  } conversion_type;

  typedef enum logic [1:0] {
    run_idle = 2'b00,
    run_busy = 2'b01,
    run_last = 2'b11
  } run_state_type;
endpackage

/* File: hw/adc_channel_sequence_config.sv */
`timescale 1ns/1ps
module adc_channel_sequence_config (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side
  input wire logic [2:0] operating_mode,
  input wire logic run_start,
  input wire adc_cfg_pkg::conversion_type conversion,
  input wire logic [11:0] window_high_limit,
  input wire logic [11:0] window_low_limit,
  output logic [3:0] convert_channel,
  output logic run_busy,
  output logic in_window,
  output logic overrun_flag,
  output logic irq
);
  logic [31:0] channel_config;
  logic [31:0] sequence_config;
  logic [31:0] accumulate_count;
  logic [31:0] next_channel_config;
  logic [31:0] next_sequence_config;
  logic [31:0] next_accumulate_count;
  logic [31:0] accumulated_result;
  logic [31:0] next_accumulated_result;
  logic [15:0] result;
  logic [15:0] next_result;
  logic result_unread;
  logic next_result_unread;
  logic [adc_cfg_pkg::irq_width-1:0] irq_status;
  logic [adc_cfg_pkg::irq_width-1:0] next_irq_status;
  logic [adc_cfg_pkg::irq_width-1:0] irq_mask;
  logic [adc_cfg_pkg::irq_width-1:0] next_irq_mask;
  logic [adc_cfg_pkg::irq_width-1:0] irq_event;
  logic [adc_cfg_pkg::irq_width-1:0] status_clear;
  logic next_in_window;
  logic next_overrun_flag;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  logic [3:0] next_convert_channel;
  logic next_run_busy;
  logic next_irq;
  logic write_access;
  logic read_access;
  logic mapped;
  logic window_hit;
  logic watched;
  logic clear_pulse;
  logic [3:0] seq_channel;
  logic seq_busy;
  logic seq_done;
  adc_cfg_pkg::config_type cfg;

  // single-cycle access: ready during every access phase
  assign write_access = psel & penable & pwrite & pready;
  assign read_access = psel & penable & ~pwrite & pready;
  assign mapped = (paddr == adc_cfg_pkg::channel_config_offset) ||
                  (paddr == adc_cfg_pkg::sequence_config_offset) ||
                  (paddr == adc_cfg_pkg::accumulate_count_offset) ||
                  (paddr == adc_cfg_pkg::irq_status_offset) ||
                  (paddr == adc_cfg_pkg::irq_mask_offset) ||
                  (paddr == adc_cfg_pkg::accumulated_result_offset) ||
                  (paddr == adc_cfg_pkg::result_offset);

  always_comb begin
    cfg.all_channel_window_enable = channel_config[adc_cfg_pkg::all_window_bit];
    cfg.window_monitor_channel_select =
      channel_config[adc_cfg_pkg::window_channel_lsb +: 4];
    cfg.justify_left = channel_config[adc_cfg_pkg::justify_bit];
    cfg.discard_new = channel_config[adc_cfg_pkg::discard_bit];
    cfg.single_channel_select = channel_config[adc_cfg_pkg::single_channel_lsb +: 4];
    cfg.accumulate_enable = accumulate_count[adc_cfg_pkg::accumulate_enable_bit];
    cfg.conversion_count = accumulate_count[adc_cfg_pkg::count_lsb +: 8];
    cfg.sequence_length = sequence_config[adc_cfg_pkg::sequence_length_lsb +: 2];
    cfg.sequence_slots = sequence_config[15:0];
  end

  adc_run_sequencer sequencer (
    .pclk(pclk),
    .presetn(presetn),
    .start(run_start),
    .mode(operating_mode),
    .cfg(cfg),
    .conversion_done(conversion.valid),
    .channel(seq_channel),
    .busy(seq_busy),
    .run_done(seq_done)
  );

  // all channels, selected channel, monitor field
  assign watched = cfg.all_channel_window_enable ||
                   (conversion.channel == cfg.window_monitor_channel_select);
  assign window_hit = (conversion.value >= window_low_limit) &&
                      (conversion.value < window_high_limit);
  assign clear_pulse = write_access &&
                       (paddr == adc_cfg_pkg::accumulate_count_offset) &&
                       pwdata[adc_cfg_pkg::accumulator_clear_bit];

  always_comb begin
    irq_event = '0;
    irq_event[adc_cfg_pkg::irq_conversion_done] = conversion.valid;
    irq_event[adc_cfg_pkg::irq_in_window] = conversion.valid & watched & window_hit;
    irq_event[adc_cfg_pkg::irq_overrun] = conversion.valid & result_unread;
    irq_event[adc_cfg_pkg::irq_run_done] = seq_done;
  end

  always_comb begin
    next_channel_config = channel_config;
    next_sequence_config = sequence_config;
    next_accumulate_count = accumulate_count;
    next_irq_mask = irq_mask;
    if (write_access) begin
      case (paddr)
        adc_cfg_pkg::channel_config_offset: begin
          next_channel_config = pwdata & adc_cfg_pkg::channel_config_mask;
        end
        adc_cfg_pkg::sequence_config_offset: begin
          next_sequence_config = pwdata & adc_cfg_pkg::sequence_config_mask;
        end
        adc_cfg_pkg::accumulate_count_offset: begin
          next_accumulate_count = pwdata & adc_cfg_pkg::accumulate_count_mask &
                                  ~(32'h0000_0001 << adc_cfg_pkg::accumulator_clear_bit);
        end
        adc_cfg_pkg::irq_mask_offset: begin
          next_irq_mask = pwdata[adc_cfg_pkg::irq_width-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // status bits are sticky and cleared by writing one; an event in the
  // clearing cycle wins, so software never loses an event
  generate
    for (genvar index = 0; index < adc_cfg_pkg::irq_width; index++) begin : g_status
      assign status_clear[index] = write_access && pwdata[index] &&
                                   (paddr == adc_cfg_pkg::irq_status_offset);
      assign next_irq_status[index] = irq_event[index] |
                                      (irq_status[index] & ~status_clear[index]);
    end
  endgenerate

  always_comb begin
    next_result = result;
    next_result_unread = result_unread;
    if (read_access && paddr == adc_cfg_pkg::result_offset) begin
      next_result_unread = 1'b0;
    end
    if (conversion.valid) begin
      // keep old when discarding an unread result
      if (!(cfg.discard_new && result_unread)) begin
        if (cfg.justify_left) begin
          next_result = {conversion.value, 4'h0};
        end else begin
          next_result = {4'h0, conversion.value};
        end
      end
      next_result_unread = 1'b1;
    end
  end

  // the clear write wins over an add in the same cycle
  always_comb begin
    next_accumulated_result = accumulated_result;
    // accumulate only when enabled, add each result
    if (clear_pulse) begin
      next_accumulated_result = 32'h0000_0000;
    end else if (conversion.valid && cfg.accumulate_enable) begin
      next_accumulated_result = accumulated_result + {20'h00000, conversion.value};
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = psel & ~penable;
    if (psel && !penable) begin
      next_pslverr = ~mapped;
      case (paddr)
        adc_cfg_pkg::channel_config_offset: next_prdata = channel_config;
        adc_cfg_pkg::sequence_config_offset: next_prdata = sequence_config;
        adc_cfg_pkg::accumulate_count_offset: next_prdata = accumulate_count;
        adc_cfg_pkg::irq_status_offset: next_prdata = {28'h0000000, irq_status};
        adc_cfg_pkg::irq_mask_offset: next_prdata = {28'h0000000, irq_mask};
        adc_cfg_pkg::accumulated_result_offset: next_prdata = accumulated_result;
        adc_cfg_pkg::result_offset: next_prdata = {16'h0000, result};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // outputs are registered copies so each one leaves a flip-flop
  always_comb begin
    next_in_window = in_window;
    if (conversion.valid && watched) begin
      next_in_window = window_hit;
    end
    next_overrun_flag = irq_status[adc_cfg_pkg::irq_overrun];
    next_convert_channel = seq_channel;
    next_run_busy = seq_busy;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_config <= adc_cfg_pkg::config_reset;
      sequence_config <= adc_cfg_pkg::config_reset;
      accumulate_count <= adc_cfg_pkg::config_reset;
    end else begin
      channel_config <= next_channel_config;
      sequence_config <= next_sequence_config;
      accumulate_count <= next_accumulate_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 16'h0000;
      result_unread <= 1'b0;
    end else begin
      result <= next_result;
      result_unread <= next_result_unread;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulated_result <= 32'h0000_0000;
    end else begin
      accumulated_result <= next_accumulated_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_window <= 1'b0;
      overrun_flag <= 1'b0;
      convert_channel <= 4'h0;
      run_busy <= 1'b0;
      irq <= 1'b0;
    end else begin
      in_window <= next_in_window;
      overrun_flag <= next_overrun_flag;
      convert_channel <= next_convert_channel;
      run_busy <= next_run_busy;
      irq <= next_irq;
    end
  end
endmodule

/* File: hw/adc_run_sequencer.sv */
`timescale 1ns/1ps
module adc_run_sequencer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic [2:0] mode,
  input wire adc_cfg_pkg::config_type cfg,
  input wire logic conversion_done,
  // outputs
  output logic [3:0] channel,
  output logic busy,
  output logic run_done
);
  adc_cfg_pkg::run_state_type state;
  adc_cfg_pkg::run_state_type next_state;
  logic [7:0] done_count;
  logic [7:0] next_done_count;
  logic [1:0] slot;
  logic [1:0] next_slot;
  logic next_run_done;
  logic is_sequence;
  logic counted;
  logic slot_end;

  assign is_sequence = mode[2] | (mode == 3'h3);
  assign counted = (mode == adc_cfg_pkg::mode_single_multiple) ||
                   (mode == adc_cfg_pkg::mode_sequence_multiple);
  assign slot_end = (slot == cfg.sequence_length);

  always_comb begin
    next_state = state;
    next_done_count = done_count;
    next_slot = slot;
    next_run_done = 1'b0;
    case (state)
      adc_cfg_pkg::run_idle: begin
        if (start) begin
          next_state = adc_cfg_pkg::run_busy;
          next_done_count = 8'h00;
          next_slot = 2'h0;
        end
      end
      adc_cfg_pkg::run_busy: begin
        if (conversion_done) begin
          if (is_sequence && !slot_end) begin
            next_slot = slot + 2'h1;
          end else begin
            next_slot = 2'h0;
            if (counted && done_count != cfg.conversion_count) begin
              next_done_count = done_count + 8'h01;
            end else if (counted || mode == adc_cfg_pkg::mode_single_once ||
                         mode == 3'h4) begin
              next_state = adc_cfg_pkg::run_last;
            end
          end
        end
      end
      adc_cfg_pkg::run_last: begin
        next_run_done = 1'b1;
        next_state = adc_cfg_pkg::run_idle;
      end
      default: next_state = adc_cfg_pkg::run_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_cfg_pkg::run_idle;
      done_count <= 8'h00;
      slot <= 2'h0;
      run_done <= 1'b0;
    end else begin
      state <= next_state;
      done_count <= next_done_count;
      slot <= next_slot;
      run_done <= next_run_done;
    end
  end

  // slot picks channel, otherwise single select
  always_comb begin
    if (is_sequence) begin
      channel = cfg.sequence_slots[slot*4 +: 4];
    end else begin
      channel = cfg.single_channel_select;
    end
  end
  assign busy = (state != adc_cfg_pkg::run_idle);
endmodule

/* File: test/adc_cfg_asserts.sv */
`timescale 1ns/1ps
module adc_cfg_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter
  input wire logic run_start,
  input wire adc_cfg_pkg::conversion_type conversion,
  input wire logic [11:0] window_high_limit,
  input wire logic [11:0] window_low_limit,
  input wire logic run_busy,
  input wire logic in_window
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && !pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_error: assert property (rd && !(paddr inside {8'h04, 8'h0C, 8'h10, 8'h40,
    8'h44, 8'h48, 8'h4C}) |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  a_channel_reserved_zero: assert property
    (rd && paddr == 8'h04 |-> (prdata & 32'hFFFF_D090) == 32'h0)
    else $error("channel word reserved bit set");
  a_sequence_reserved_zero: assert property
    (rd && paddr == 8'h0C |-> prdata[31:18] == 14'h0) else $error("sequence reserved bit set");
  a_clear_reads_zero: assert property
    (rd && paddr == 8'h10 |-> prdata[31:9] == 23'h0) else $error("clear bit reads one");
  a_window_bounds: assert property
    ($rose(in_window) |-> $past(conversion.valid) && $past(conversion.value) >=
    $past(window_low_limit) && $past(conversion.value) < $past(window_high_limit))
    else $error("in_window outside limits");
  a_window_cause: assert property
    ($changed(in_window) |-> $past(conversion.valid)) else $error("in_window moved alone");
  a_busy_from_start: assert property
    ($rose(run_busy) |-> $past(run_start, 2)) else $error("run_busy without start");
endmodule
bind adc_channel_sequence_config adc_cfg_asserts u_asserts (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .run_start, .conversion,
  .window_high_limit, .window_low_limit, .run_busy, .in_window);

/* File: test/test_adc_channel_sequence_config.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module test_adc_channel_sequence_config;
  logic pclk, presetn, psel, penable, pwrite, run_start, pready, pslverr;
  logic run_busy, in_window, overrun_flag, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [2:0] operating_mode;
  logic [11:0] window_high_limit, window_low_limit;
  logic [3:0] convert_channel;
  adc_cfg_pkg::conversion_type conversion;
  logic [32:0] exp_q[$];
  logic [32:0] got;
  logic [7:0] offs[4] = '{8'h04, 8'h0C, 8'h10, 8'h48};
  logic [31:0] masks[3] = '{32'h0000_2F6F, 32'h0003_FFFF, 32'h0000_01FF};
  // window table: config, channel, value, expected in_window
  logic [32:0] wtab[4] = '{{16'h0500, 4'h5, 12'h100, 1'b1}, {16'h0500, 4'h5, 12'h200, 1'b0},
    {16'h0500, 4'h2, 12'h150, 1'b0}, {16'h2500, 4'h2, 12'h150, 1'b1}};
  int n_mismatch, cmp_count, seed;

  adc_channel_sequence_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .operating_mode(operating_mode),
    .run_start(run_start), .conversion(conversion), .window_high_limit(window_high_limit),
    .window_low_limit(window_low_limit), .convert_channel(convert_channel),
    .run_busy(run_busy), .in_window(in_window), .overrun_flag(overrun_flag), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task stop_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // waits for pready however long it takes; only the watchdog ends a hung transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // expected read result is noted before the bus cycle starts
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // valid is one cycle; the payload is scrambled afterwards so stale data cannot match
  task conv(input logic [3:0] c, input logic [11:0] v);
    @(posedge pclk);
    conversion <= {1'b1, c, v};
    @(posedge pclk);
    conversion <= {1'b0, ~c, ~v};
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      got = exp_q.pop_front();
      `CHK("read", got, {pslverr, prdata})
    end
  end

  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; run_start = 0;
    operating_mode = 0; window_low_limit = 12'h100; window_high_limit = 12'h200;
    conversion = '0; presetn = 0; seed = 40; n_mismatch = 0; cmp_count = 0;
    tick(2);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 33'h0);
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      apb(1'b1, offs[i % 3], rnd & (masks[i % 3] | 32'h0000_0200));
      rd(offs[i % 3], {1'b0, rnd & masks[i % 3]});
    end
    rd(8'h20, {1'b1, 32'h0});
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h04, 32'h40);
    conv(4'h1, 12'hABC);
    rd(8'h4C, 33'h0ABC0);
    apb(1'b1, 8'h04, 32'h0);
    conv(4'h1, 12'h5A5);
    rd(8'h4C, 33'h005A5);
    apb(1'b1, 8'h04, 32'h20);
    conv(4'h1, 12'h111);
    conv(4'h1, 12'h222);
    rd(8'h4C, 33'h00111);
    `CHK("overrun_flag", 1'b1, overrun_flag)
    apb(1'b1, 8'h04, 32'h0);
    conv(4'h1, 12'h333);
    conv(4'h1, 12'h444);
    rd(8'h4C, 33'h00444);
    apb(1'b1, 8'h44, 32'h4);
    tick(2);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, 8'h40, 32'h4);
    tick(2);
    `CHK("irq", 1'b0, irq)
    `CHK("overrun_flag", 1'b0, overrun_flag)
    apb(1'b1, 8'h44, 32'h0);
    conv(4'h1, 12'h001);
    conv(4'h1, 12'h002);
    tick(2);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, 8'h10, 32'h200);
    apb(1'b1, 8'h10, 32'h100);
    conv(4'h1, 12'h123);
    conv(4'h1, 12'h011);
    rd(8'h48, 33'h134);
    apb(1'b1, 8'h10, 32'h0);
    conv(4'h1, 12'h100);
    rd(8'h48, 33'h134);
    apb(1'b1, 8'h10, 32'h200);
    rd(8'h48, 33'h0);
    rd(8'h10, 33'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, {16'h0, wtab[i][32:17]});
      conv(wtab[i][16:13], wtab[i][12:1]);
      tick(2);
      `CHK("in_window", wtab[i][0], in_window)
    end
    // two slots, count one: four conversions alternating slot channels
    apb(1'b1, 8'h0C, 32'h0001_0073);
    apb(1'b1, 8'h10, 32'h1);
    operating_mode <= 3'h5;
    @(posedge pclk) run_start <= 1'b1;
    @(posedge pclk) run_start <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      tick(3);
      `CHK("convert_channel", (i % 2) ? 4'h7 : 4'h3, convert_channel)
      `CHK("run_busy", 1'b1, run_busy)
      conv((i % 2) ? 4'h7 : 4'h3, 12'h001);
    end
    tick(4);
    `CHK("run_busy", 1'b0, run_busy)
    operating_mode <= 3'h0;
    apb(1'b1, 8'h04, 32'h9);
    tick(2);
    `CHK("convert_channel", 4'h9, convert_channel)
    @(posedge pclk) run_start <= 1'b1;
    @(posedge pclk) run_start <= 1'b0;
    tick(3);
    `CHK("run_busy", 1'b1, run_busy)
    conv(4'h9, 12'h001);
    tick(4);
    `CHK("run_busy", 1'b0, run_busy)
    // single multiple runs count plus one; scan makes one pass of both slots
    for (int m = 0; m < 2; m++) begin
      operating_mode <= m ? 3'h4 : 3'h1;
      @(posedge pclk) run_start <= 1'b1;
      @(posedge pclk) run_start <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        tick(3);
        `CHK("convert_channel", m ? (i ? 4'h7 : 4'h3) : 4'h9, convert_channel)
        `CHK("run_busy", 1'b1, run_busy)
        conv(convert_channel, 12'h001);
      end
      tick(4);
      `CHK("run_busy", 1'b0, run_busy)
    end
    // a reset after the run ends brings every configuration word back to zero
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 33'h0);
    tick(2);
    stop_test();
  end
endmodule
